// ==== spr_defines.vh ====
// constants for the sleep and power reduction control block
`ifndef SPR_DEFINES_VH
`define SPR_DEFINES_VH

// register offsets on the plain register port
`define SPR_OFS_SLEEP       8'h00
`define SPR_OFS_MCU         8'h01
`define SPR_OFS_GATE        8'h02

// sleep mode control fields
`define SPR_SE_BIT          0
`define SPR_SM_HI           2
`define SPR_SM_LO           1

// sleep mode encodings
`define SPR_MODE_IDLE       2'b00
`define SPR_MODE_ADCNR      2'b01
`define SPR_MODE_PDOWN      2'b10
`define SPR_MODE_RSVD       2'b11

// mcu control fields
`define SPR_BROWNOUT_SLEEP_DISABLE_BIT        6
`define SPR_BROWNOUT_SLEEP_DISABLE_UNLOCK_BIT       5

// peripheral clock gate fields
`define SPR_GATE_TWI_BIT    7
`define SPR_GATE_TIM0_BIT   5
`define SPR_GATE_TIM1_BIT   3
`define SPR_GATE_SPI_BIT    2
`define SPR_GATE_ADC_BIT    0
`define SPR_GATE_RESET      5'h00

// timed sequence and wake timing counts, in clock cycles
`define SPR_UNLOCK_WIN      3'h4
`define SPR_BROWNOUT_SLEEP_DISABLE_DLY        3'h3
`define SPR_BROWNOUT_SLEEP_DISABLE_END        3'h6
`define SPR_HALT_CYC        3'h4

// sleep sequencer states
`define SPR_ST_ACTIVE       2'b00
`define SPR_ST_SLEEP        2'b01
`define SPR_ST_STARTUP      2'b10
`define SPR_ST_HALT         2'b11

`endif

// ==== spr_delay_cnt.v ====
// reloadable down counter used for reset stretching and wake-up delays
`timescale 1ns/10ps
`default_nettype none

module spr_delay_cnt #(
    parameter W = 16
) (
    // clock and reset
    input  wire         clk_i,
    input  wire         rst_b_i,
    // control
    input  wire         start_i,
    input  wire [W-1:0] load_i,
    // status
    output reg          busy_o,
    output reg          done_o
);

    reg [W-1:0] count;

    // start reloads at any time, done pulses once at the end
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            count  <= {W{1'b0}};
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i)
            begin
                count  <= load_i;
                busy_o <= 1'b1;
            end
            else if (busy_o)
            begin
                if (count <= {{(W-1){1'b0}}, 1'b1})
                begin
                    count  <= {W{1'b0}};
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                else
                begin
                    count <= count - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule

`default_nettype wire

// ==== spr_ctrl.v ====
// sleep, brown-out sleep disable, peripheral clock gating and reset stretch control
`timescale 1ns/10ps
`default_nettype none
`include "spr_defines.vh"

module spr_ctrl #(
    parameter        NPIN           = 8,
    parameter        CW             = 16,
    parameter [15:0] TOUT_CYCLES    = 16'h4000,
    parameter [15:0] STARTUP_CYCLES = 16'h0010
) (
    // clock and reset
    input  wire            clk_i,
    input  wire            rst_b_i,
    // register port
    input  wire [7:0]      addr_i,
    input  wire [7:0]      wdata_i,
    input  wire            wr_i,
    input  wire            rd_i,
    output reg  [7:0]      rd_data_o,
    // cpu handshake
    input  wire            sleep_instr_i,
    input  wire            wake_i,
    output reg             cpu_clk_en_o,
    output reg             cpu_reset_o,
    // fuses and watchdog
    input  wire            bod_fuse_i,
    input  wire            debug_enable_fuse_i,
    input  wire [1:0]      startup_time_fuses_i,
    input  wire [1:0]      clock_select_fuses_i,
    input  wire            wdt_enable_i,
    // reset sources, combined, from pins
    input  wire            rst_src_b_i,
    output wire            pin_reset_o,
    // pin input buffers
    input  wire [NPIN-1:0] wake_keep_i,
    output reg  [NPIN-1:0] inbuf_en_o,
    // clock domains and analog enables
    output reg             io_clk_en_o,
    output reg             adc_clk_en_o,
    output reg             main_osc_en_o,
    output reg             wdt_clk_en_o,
    output reg             bod_en_o,
    output reg             comparator_en_o,
    // peripheral clocks and access: 4 two-wire, 3 timer0, 2 timer1, 1 serial, 0 converter
    output reg  [4:0]      periph_clk_en_o,
    output reg  [4:0]      periph_access_en_o
);

    // register state
    reg        sleep_en;
    reg [1:0]  sleep_mode;
    reg [4:0]  gate;
    reg [2:0]  unlock_win;
    reg [2:0]  brownout_sleep_disable_age;
    reg        brownout_sleep_disable;
    reg        bod_off_sleep;
    reg [1:0]  state;
    reg [2:0]  halt_cnt;
    reg        int_rst;
    reg        src_meta;
    reg        src_sync;

    // combinational next values
    reg        next_io_run;
    reg        next_adc_run;
    reg        next_deep;
    reg [4:0]  next_clk;
    reg [7:0]  next_rd;

    wire       src_active;
    wire       regs_clr;
    wire       brownout_sleep_disable_active;
    wire       sleep_go;
    wire       stretch_busy;
    wire       stretch_done;
    wire       stretch_start;
    wire       wake_busy;
    wire       wake_done;
    wire       wake_start;
    wire [2:0] tout_shift;
    wire [CW-1:0] tout_cycles;
    wire [CW-1:0] wake_load;
    wire       sleeping;

    // register address decode, used by writes and reads
    function sel;
        input [7:0] a;
        input [7:0] ofs;
        begin
            sel = (a == ofs);
        end
    endfunction

    // reset source line synchroniser
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            src_meta <= 1'b0;
            src_sync <= 1'b0;
        end
        else
        begin
            src_meta <= rst_src_b_i;
            src_sync <= src_meta;
        end
    end

    assign src_active = ~src_sync;

    // pins drop to reset state without waiting for a clock edge
    assign pin_reset_o = ~rst_src_b_i | int_rst;

    // time-out chosen by fuses
    assign tout_shift    = {1'b0, startup_time_fuses_i} + {1'b0, clock_select_fuses_i};
    assign tout_cycles   = TOUT_CYCLES[CW-1:0] >> tout_shift;
    assign stretch_start = src_active | (int_rst & ~stretch_busy & ~stretch_done);

    spr_delay_cnt #(
        .W       (CW)
    ) u_stretch (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .start_i (stretch_start),
        .load_i  (tout_cycles),
        .busy_o  (stretch_busy),
        .done_o  (stretch_done)
    );

    // internal reset held while sources active and until the count expires
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
            int_rst <= 1'b1;
        else if (src_active)
            int_rst <= 1'b1;
        else if (stretch_done)
            int_rst <= 1'b0;
    end

    assign regs_clr = ~rst_b_i | int_rst;

    // sleep entry only with enable set and a real mode selected
    assign sleep_go = sleep_instr_i & sleep_en & (state == `SPR_ST_ACTIVE)
                    & (sleep_mode != `SPR_MODE_RSVD);

    // active for ages three to five, the clearing cycle itself no longer counts
    assign brownout_sleep_disable_active = brownout_sleep_disable & (brownout_sleep_disable_age >= `SPR_BROWNOUT_SLEEP_DISABLE_DLY)
                       & (brownout_sleep_disable_age != `SPR_BROWNOUT_SLEEP_DISABLE_END);

    // register writes and the timed brown-out disable sequence
    always @(posedge clk_i)
    begin
        if (regs_clr)
        begin
            sleep_en   <= 1'b0;
            sleep_mode <= `SPR_MODE_IDLE;
            gate       <= `SPR_GATE_RESET;
            unlock_win <= 3'h0;
            brownout_sleep_disable_age   <= 3'h0;
            brownout_sleep_disable       <= 1'b0;
        end
        else
        begin
            if (unlock_win != 3'h0)
                unlock_win <= unlock_win - 3'h1;
            // self clearing after the active period
            if (brownout_sleep_disable)
            begin
                if (brownout_sleep_disable_age == `SPR_BROWNOUT_SLEEP_DISABLE_END)
                begin
                    brownout_sleep_disable     <= 1'b0;
                    brownout_sleep_disable_age <= 3'h0;
                end
                else
                    brownout_sleep_disable_age <= brownout_sleep_disable_age + 3'h1;
            end
            if (wr_i && sel(addr_i, `SPR_OFS_SLEEP))
            begin
                sleep_en   <= wdata_i[`SPR_SE_BIT];
                sleep_mode <= wdata_i[`SPR_SM_HI:`SPR_SM_LO];
            end
            if (wr_i && sel(addr_i, `SPR_OFS_MCU))
            begin
                if (wdata_i[`SPR_BROWNOUT_SLEEP_DISABLE_BIT] && wdata_i[`SPR_BROWNOUT_SLEEP_DISABLE_UNLOCK_BIT])
                    unlock_win <= `SPR_UNLOCK_WIN;
                else
                begin
                    unlock_win <= 3'h0;
                    if (wdata_i[`SPR_BROWNOUT_SLEEP_DISABLE_BIT] && (unlock_win != 3'h0))
                    begin
                        brownout_sleep_disable     <= 1'b1;
                        brownout_sleep_disable_age <= 3'h1;
                    end
                end
            end
            if (wr_i && sel(addr_i, `SPR_OFS_GATE))
            begin
                gate[4] <= wdata_i[`SPR_GATE_TWI_BIT];
                gate[3] <= wdata_i[`SPR_GATE_TIM0_BIT];
                gate[2] <= wdata_i[`SPR_GATE_TIM1_BIT];
                gate[1] <= wdata_i[`SPR_GATE_SPI_BIT];
                gate[0] <= wdata_i[`SPR_GATE_ADC_BIT];
            end
        end
    end

    // wake delay: reset time-out after detector-off sleep, else mode start-up
    assign wake_load  = bod_off_sleep ? tout_cycles :
                        (sleep_mode == `SPR_MODE_PDOWN) ? STARTUP_CYCLES[CW-1:0] :
                        {{(CW-1){1'b0}}, 1'b1};
    assign wake_start = (state == `SPR_ST_SLEEP) & wake_i;

    spr_delay_cnt #(
        .W       (CW)
    ) u_wake (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .start_i (wake_start),
        .load_i  (wake_load),
        .busy_o  (wake_busy),
        .done_o  (wake_done)
    );

    // sleep sequencer
    always @(posedge clk_i)
    begin
        if (regs_clr)
        begin
            state         <= `SPR_ST_ACTIVE;
            halt_cnt      <= 3'h0;
            bod_off_sleep <= 1'b0;
        end
        else
        begin
            case (state)
                `SPR_ST_ACTIVE:
                begin
                    if (sleep_go)
                    begin
                        state         <= `SPR_ST_SLEEP;
                        bod_off_sleep <= brownout_sleep_disable_active;
                    end
                end
                `SPR_ST_SLEEP:
                begin
                    if (wake_i)
                        state <= `SPR_ST_STARTUP;
                end
                `SPR_ST_STARTUP:
                begin
                    if (wake_done)
                    begin
                        state    <= `SPR_ST_HALT;
                        halt_cnt <= `SPR_HALT_CYC;
                    end
                end
                `SPR_ST_HALT:
                begin
                    if (halt_cnt <= 3'h1)
                    begin
                        state         <= `SPR_ST_ACTIVE;
                        halt_cnt      <= 3'h0;
                        bod_off_sleep <= 1'b0;
                    end
                    else
                        halt_cnt <= halt_cnt - 3'h1;
                end
                default:
                    state <= `SPR_ST_ACTIVE;
            endcase
        end
    end

    assign sleeping = (state == `SPR_ST_SLEEP) | (state == `SPR_ST_STARTUP);

    // clock domain and gate decode
    integer i;
    always @*
    begin
        next_io_run  = ~sleeping | (sleep_mode == `SPR_MODE_IDLE);
        next_adc_run = ~sleeping | (sleep_mode != `SPR_MODE_PDOWN);
        next_deep    = sleeping & (sleep_mode == `SPR_MODE_PDOWN);
        for (i = 0; i < 5; i = i + 1)
        begin
            // converter on its own domain, the rest on the io domain
            if (i == 0)
                next_clk[i] = next_adc_run & ~gate[i];
            else
                next_clk[i] = next_io_run & ~gate[i];
        end
    end

    // read mux, unused bits held at zero
    always @*
    begin
        next_rd = 8'h00;
        if (sel(addr_i, `SPR_OFS_SLEEP))
        begin
            next_rd[`SPR_SE_BIT]            = sleep_en;
            next_rd[`SPR_SM_HI:`SPR_SM_LO]  = sleep_mode;
        end
        else if (sel(addr_i, `SPR_OFS_MCU))
        begin
            next_rd[`SPR_BROWNOUT_SLEEP_DISABLE_BIT]  = brownout_sleep_disable;
            next_rd[`SPR_BROWNOUT_SLEEP_DISABLE_UNLOCK_BIT] = (unlock_win != 3'h0);
        end
        else if (sel(addr_i, `SPR_OFS_GATE))
        begin
            next_rd[`SPR_GATE_TWI_BIT]  = gate[4];
            next_rd[`SPR_GATE_TIM0_BIT] = gate[3];
            next_rd[`SPR_GATE_TIM1_BIT] = gate[2];
            next_rd[`SPR_GATE_SPI_BIT]  = gate[1];
            next_rd[`SPR_GATE_ADC_BIT]  = gate[0];
        end
    end

    // registered outputs
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            rd_data_o          <= 8'h00;
            cpu_clk_en_o       <= 1'b0;
            cpu_reset_o        <= 1'b1;
            inbuf_en_o         <= {NPIN{1'b0}};
            io_clk_en_o        <= 1'b0;
            adc_clk_en_o       <= 1'b0;
            main_osc_en_o      <= 1'b1;
            wdt_clk_en_o       <= 1'b0;
            bod_en_o           <= 1'b0;
            comparator_en_o    <= 1'b0;
            periph_clk_en_o    <= 5'h00;
            periph_access_en_o <= 5'h00;
        end
        else
        begin
            rd_data_o          <= (rd_i && !int_rst) ? next_rd : 8'h00;
            cpu_reset_o        <= int_rst;
            cpu_clk_en_o       <= (state == `SPR_ST_ACTIVE) & ~int_rst;
            inbuf_en_o         <= {NPIN{~next_deep}} | wake_keep_i;
            io_clk_en_o        <= next_io_run;
            adc_clk_en_o       <= next_adc_run;
            main_osc_en_o      <= ~next_deep | debug_enable_fuse_i;
            wdt_clk_en_o       <= wdt_enable_i;
            bod_en_o           <= bod_fuse_i
                                & ~((state == `SPR_ST_SLEEP) & bod_off_sleep);
            comparator_en_o    <= ~gate[0];
            periph_clk_en_o    <= next_clk;
            periph_access_en_o <= ~gate;
        end
    end

endmodule

`default_nettype wire

// ==== spr_ctrl_tail_unused.v ====
// empty source, holds no module
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ==== spr_ctrl_props.sv ====
// assertion checker for the sleep and power reduction control block
`timescale 1ns/10ps
`default_nettype none

module spr_ctrl_props #(
    parameter NPIN = 8
) (
    // clock, reset and register port
    input wire logic            clk_i,
    input wire logic            rst_b_i,
    input wire logic [7:0]      addr_i,
    input wire logic            rd_i,
    input wire logic [7:0]      rd_data_o,
    // cpu, fuses and reset sources
    input wire logic            sleep_instr_i,
    input wire logic            cpu_clk_en_o,
    input wire logic            cpu_reset_o,
    input wire logic            debug_enable_fuse_i,
    input wire logic            wdt_enable_i,
    input wire logic            rst_src_b_i,
    input wire logic            pin_reset_o,
    // pins and clock enables
    input wire logic [NPIN-1:0] wake_keep_i,
    input wire logic [NPIN-1:0] inbuf_en_o,
    input wire logic            io_clk_en_o,
    input wire logic            adc_clk_en_o,
    input wire logic            main_osc_en_o,
    input wire logic            wdt_clk_en_o,
    input wire logic            comparator_en_o,
    input wire logic [4:0]      periph_clk_en_o,
    input wire logic [4:0]      periph_access_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    // register read data and sleep entry
    chk_rsvd_bits_zero: assert property (
        $past(rd_i) |-> (rd_data_o & ($past(addr_i) == 8'h00 ? 8'hf8 :
        $past(addr_i) == 8'h01 ? 8'h8f : $past(addr_i) == 8'h02 ? 8'h52 : 8'hff)) == 8'h00)
        else $error("reserved read bits not zero");
    chk_sleep_cause: assert property (
        $fell(cpu_clk_en_o) && !pin_reset_o |->
        $past(sleep_instr_i) || $past(sleep_instr_i, 2) || $past(sleep_instr_i, 3))
        else $error("cpu clock stopped without sleep");
    // peripheral gating
    chk_gate_access: assert property (
        cpu_clk_en_o |-> periph_clk_en_o == periph_access_en_o)
        else $error("peripheral clock and access differ");
    chk_cmp_gated: assert property (
        !periph_access_en_o[0] |-> !comparator_en_o)
        else $error("comparator on while converter gated");
    chk_deep_gates: assert property (
        !io_clk_en_o && !adc_clk_en_o |-> periph_clk_en_o == 5'h00)
        else $error("peripheral clock in deep sleep");
    // pins, oscillator and watchdog in sleep
    chk_inbuf_off: assert property (
        !io_clk_en_o && !adc_clk_en_o |-> (inbuf_en_o & ~wake_keep_i) == {NPIN{1'b0}})
        else $error("input buffer left on in deep sleep");
    chk_debug_osc: assert property (
        debug_enable_fuse_i && $past(debug_enable_fuse_i) |-> main_osc_en_o)
        else $error("oscillator off with debug fuse");
    chk_wdt_runs: assert property (
        wdt_enable_i && $past(wdt_enable_i) && !cpu_reset_o |-> wdt_clk_en_o)
        else $error("watchdog clock stopped");
    // reset sources
    chk_pin_reset: assert property (
        !rst_src_b_i |-> pin_reset_o)
        else $error("pin reset missing");
    chk_reset_stretch: assert property (
        $rose(rst_src_b_i) |-> ##4 cpu_reset_o [*8])
        else $error("internal reset not stretched");

    // main scenarios reached
    cov_sleep: cover property ($fell(cpu_clk_en_o) && !pin_reset_o);
    cov_stretch: cover property ($rose(rst_src_b_i));
    cov_gated: cover property (cpu_clk_en_o && periph_access_en_o == 5'h00);
endmodule

`default_nettype wire

// ==== spr_ctrl_test.sv ====
// self-checking bench for the sleep and power reduction control block
`timescale 1ns/10ps
`default_nettype none

module spr_ctrl_test;
    localparam int          TOUT = 64;
    localparam int          STUP = 4;
    localparam logic [7:0]  KEEP = 8'h0c;
    // design inputs
    logic       clk_i = 1'b0;
    logic       rst_b_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic       sleep_instr_i = 1'b0;
    logic       wake_i = 1'b0;
    logic       bod_fuse_i = 1'b0;
    logic       debug_enable_fuse_i = 1'b0;
    logic [1:0] startup_time_fuses_i = 2'h0;
    logic [1:0] clock_select_fuses_i = 2'h0;
    logic       wdt_enable_i = 1'b1;
    logic       rst_src_b_i = 1'b1;
    logic [7:0] wake_keep_i = KEEP;
    // design outputs
    wire  [7:0] rd_data_o;
    wire  [7:0] inbuf_en_o;
    wire  [4:0] periph_clk_en_o;
    wire  [4:0] periph_access_en_o;
    wire        cpu_clk_en_o, cpu_reset_o, pin_reset_o, io_clk_en_o, adc_clk_en_o;
    wire        main_osc_en_o, wdt_clk_en_o, bod_en_o, comparator_en_o;
    int         err_total = 0;
    int         tests_run = 0;

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    // design with short time-outs
    spr_ctrl #(.NPIN(8), .TOUT_CYCLES(16'(TOUT)), .STARTUP_CYCLES(16'(STUP))) u_dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .sleep_instr_i(sleep_instr_i),
        .wake_i(wake_i), .cpu_clk_en_o(cpu_clk_en_o), .cpu_reset_o(cpu_reset_o),
        .bod_fuse_i(bod_fuse_i), .debug_enable_fuse_i(debug_enable_fuse_i),
        .startup_time_fuses_i(startup_time_fuses_i), .wdt_enable_i(wdt_enable_i),
        .clock_select_fuses_i(clock_select_fuses_i), .rst_src_b_i(rst_src_b_i),
        .pin_reset_o(pin_reset_o), .wake_keep_i(wake_keep_i), .inbuf_en_o(inbuf_en_o),
        .io_clk_en_o(io_clk_en_o), .adc_clk_en_o(adc_clk_en_o),
        .main_osc_en_o(main_osc_en_o), .wdt_clk_en_o(wdt_clk_en_o), .bod_en_o(bod_en_o),
        .comparator_en_o(comparator_en_o), .periph_clk_en_o(periph_clk_en_o),
        .periph_access_en_o(periph_access_en_o));

    // count and report
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic stuck(input int n, input int lim);
        if (n >= lim)
        begin
            err_total++;
            $display("[ERR] wait expected done seen timeout");
            give_verdict;
        end
    endtask

    // register port: strobes held until the next edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_i <= 1'b1;
        rd_i <= 1'b0;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string nm);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        chk(nm, e, rd_data_o);
    endtask
    task automatic idle(input int n);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        repeat (n) @(posedge clk_i);
    endtask

    // cpu side: sleep pulse, wake and stretched reset
    task automatic go_sleep;
        wr_i <= 1'b0;
        sleep_instr_i <= 1'b1;
        @(posedge clk_i);
        sleep_instr_i <= 1'b0;
        idle(3);
    endtask
    task automatic wake_check(input int s);
        int n;
        wake_i <= 1'b1;
        @(posedge clk_i);
        wake_i <= 1'b0;
        n = 0;
        do @(posedge clk_i); while (cpu_clk_en_o !== 1'b1 && ++n < 300);
        stuck(n, 300);
        chk("wake cycles", 8'(7 + s), 8'(n + 1));
    endtask
    task automatic wait_rst(output int n);
        n = 0;
        do @(posedge clk_i); while (cpu_reset_o !== 1'b0 && ++n < 600);
        stuck(n, 600);
    endtask

    // register bits and peripheral gates
    task automatic t_regs;
        logic [7:0] pos [5];
        pos = '{8'h01, 8'h04, 8'h08, 8'h20, 8'h80};
        wr(8'h00, 8'hff);
        wr(8'h01, 8'h8f);
        wr(8'h02, 8'hff);
        rdchk(8'h00, 8'h07, "sleep control");
        rdchk(8'h01, 8'h00, "mcu control");
        rdchk(8'h02, 8'had, "gate register");
        rdchk(8'h07, 8'h00, "unmapped");
        chk("all gated", 8'h00, 8'(periph_access_en_o));
        for (int i = 0; i < 5; i++)
        begin
            wr(8'h02, pos[i]);
            idle(3);
            chk("clock enables", 8'(5'h1f & ~(5'h01 << i)), 8'(periph_clk_en_o));
            chk("access enables", 8'(5'h1f & ~(5'h01 << i)), 8'(periph_access_en_o));
            chk("comparator", 8'(i != 0), 8'(comparator_en_o));
        end
        wr(8'h02, 8'h00);
        wr(8'h00, 8'h00);
        idle(3);
        chk("ungated", 8'h1f, 8'(periph_clk_en_o));
        $display("register test done");
    endtask

    // each sleep mode, then the ones that must not sleep
    task automatic t_modes;
        logic [1:0] m;
        wr(8'h02, 8'h20);
        for (int k = 0; k < 4; k++)
        begin
            m = (k == 3) ? 2'h2 : 2'(k);
            debug_enable_fuse_i <= (k == 3);
            wr(8'h00, {5'h00, m, 1'b1});
            go_sleep;
            chk("cpu clock", 8'h00, 8'(cpu_clk_en_o));
            chk("io clock", 8'(m == 2'h0), 8'(io_clk_en_o));
            chk("adc clock", 8'(m != 2'h2), 8'(adc_clk_en_o));
            chk("main osc", 8'(m != 2'h2 || k == 3), 8'(main_osc_en_o));
            chk("wdt clock", 8'h01, 8'(wdt_clk_en_o));
            if (m == 2'h2) chk("input buffers", KEEP, inbuf_en_o);
            chk("sleep gates", (m == 2'h0) ? 8'h17 : (m == 2'h1) ? 8'h01 : 8'h00,
                8'(periph_clk_en_o));
            wake_check(m == 2'h2 ? STUP : 1);
            wr(8'h00, 8'h00);
        end
        for (int k = 0; k < 2; k++)
        begin
            wr(8'h00, k ? 8'h07 : 8'h04);
            go_sleep;
            chk("no sleep", 8'h01, 8'(cpu_clk_en_o));
        end
        wr(8'h00, 8'h00);
        $display("sleep mode test done");
    endtask

    // timed detector disable: g idle cycles in the window, late cycles to sleep
    task automatic t_brownout_sleep_disable(input int g, input int late, input logic off);
        wr(8'h00, 8'h05);
        wr(8'h01, 8'h60);
        if (g > 0) idle(g);
        wr(8'h01, 8'h40);
        idle(late);
        go_sleep;
        chk("detector asleep", 8'(!off), 8'(bod_en_o));
        wake_check(off ? TOUT : STUP);
        chk("detector awake", 8'h01, 8'(bod_en_o));
        rdchk(8'h01, 8'h00, "disable cleared");
        wr(8'h00, 8'h00);
        $display("detector test %0d %0d done", g, late);
    endtask

    // reset source pulse with a shorter fuse time-out
    task automatic t_src;
        int n;
        wr(8'h02, 8'h20);
        rst_src_b_i <= 1'b0;
        startup_time_fuses_i <= 2'h1;
        idle(1);
        chk("pin reset", 8'h01, 8'(pin_reset_o));
        idle(5);
        rst_src_b_i <= 1'b1;
        wait_rst(n);
        chk("stretch in range", 8'h01, 8'(n >= TOUT / 2 && n <= TOUT / 2 + 12));
        rdchk(8'h02, 8'h00, "gate after reset");
        startup_time_fuses_i <= 2'h0;
        $display("reset source test done");
    endtask

    // main sequence
    initial
    begin
        int n;
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        wait_rst(n);
        for (int a = 0; a < 3; a++) rdchk(8'(a), 8'h00, "reset value");
        t_regs;
        t_modes;
        bod_fuse_i <= 1'b1;
        t_brownout_sleep_disable(3, 2, 1'b1);
        t_brownout_sleep_disable(4, 2, 1'b0);
        t_brownout_sleep_disable(0, 1, 1'b0);
        t_brownout_sleep_disable(0, 4, 1'b1);
        t_brownout_sleep_disable(0, 5, 1'b0);
        t_src;
        give_verdict;
    end
endmodule

bind spr_ctrl spr_ctrl_props #(.NPIN(NPIN)) u_props (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .sleep_instr_i(sleep_instr_i), .cpu_clk_en_o(cpu_clk_en_o), .cpu_reset_o(cpu_reset_o),
    .debug_enable_fuse_i(debug_enable_fuse_i), .wdt_enable_i(wdt_enable_i),
    .rst_src_b_i(rst_src_b_i), .pin_reset_o(pin_reset_o), .wake_keep_i(wake_keep_i),
    .inbuf_en_o(inbuf_en_o), .io_clk_en_o(io_clk_en_o), .adc_clk_en_o(adc_clk_en_o),
    .main_osc_en_o(main_osc_en_o), .wdt_clk_en_o(wdt_clk_en_o),
    .comparator_en_o(comparator_en_o), .periph_clk_en_o(periph_clk_en_o),
    .periph_access_en_o(periph_access_en_o));

`default_nettype wire
